// [rtl/lcdvt_pkg.sv]
/*
  Package for the LCD vertical timing block: register offsets, field
  positions, reset values and the frame sequencer states.
  Assumes a plain register port with read data one cycle after the strobe.
*/
// Summary of operation
// - In active mode the back-porch count starts once the previous frame's vertical sync has ended.
// - In passive mode the back-porch count starts only after the dummy sync-width lines are inserted.
// - The back-porch field gives 0 to 255 extra lines per frame with no offset.
// - Bits 15 to 10 hold a six-bit sync width that sets the vertical sync pulse length in active mode.
// - In passive mode the sync width inserts dummy line delays between frames instead of a pulse.
// - The sync width is stored as lines minus one, so one more line than the value is produced.
// - Bits 9 to 0 hold lines per screen as count minus one, giving 1 to 1024 lines.
// - The frame control register holds skip-fourth, bypass, clocks-per-line, slave and invert bits.
package lcdvt_pkg;
  localparam logic [31:0] LCDVT_OFS_FRAME_CONTROL = 32'h80010028;
  localparam logic [31:0] LCDVT_OFS_VERTICAL_TIMING = 32'h80010024;
  localparam int LCDVT_BP_POS = 24;
  localparam int LCDVT_FP_POS = 16;
  localparam int LCDVT_SW_POS = 10;
  localparam int LCDVT_LPS_POS = 0;
  localparam int LCDVT_INV_FRAME_POS = 11;
  localparam logic [31:0] LCDVT_VT_RESET = 32'h00000000;
  localparam logic [31:0] LCDVT_FC_RESET = 32'h00000000;
  localparam logic [31:0] LCDVT_FC_MASK = 32'h0fffffff;
  typedef enum logic [2:0] {LCDVT_SYNC, LCDVT_BACK, LCDVT_DISP, LCDVT_FRONT} lcdvt_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcdvt_bus_t;
endpackage

// [rtl/lcdvt_top.sv]
/*
  LCD vertical frame sequencer with its two timing registers.
  Assumes i_line_pulse is a one-cycle line-clock tick from horizontal
  timing logic on the same clock; i_active selects active (TFT) mode.
*/
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lcdvt_top
(
  input wire logic i_clock, // 20 MHz controller clock
  input wire logic i_rst_b, // Async reset, active low
  input wire lcdvt_pkg::lcdvt_bus_t i_bus, // Register port request
  input wire logic i_active, // 1 active mode, 0 passive
  input wire logic i_line_pulse, // One tick per line clock period
  output logic [31:0] o_rdata, // Read data, one cycle after strobe
  output logic o_frame_sync, // Vertical sync, polarity applied
  output logic o_display_line, // High during displayed lines
  output logic o_dummy_line, // Passive-mode dummy line in progress
  output logic [9:0] o_line // Current display line
);
  import lcdvt_pkg::*;

  logic [31:0] vertical_timing;
  logic [31:0] frame_control;
  lcdvt_state_t state;
  lcdvt_state_t next_state;
  logic [9:0] count;
  logic last;

  // Last count of the back porch: N lines run as counts 0 to N-1, so the field
  // needs no offset; a zero field never gets here, that phase is skipped
  function automatic logic [9:0] porch_end(input logic [7:0] lines);
    return {2'b00, lines} - 10'h001;
  endfunction

  // Register select, one bit per register; shared by write and read decode
  function automatic logic [1:0] reg_sel(input logic [31:0] addr);
    return {addr == LCDVT_OFS_FRAME_CONTROL, addr == LCDVT_OFS_VERTICAL_TIMING};
  endfunction

  // Register writes; the frame control top nibble is reserved
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      vertical_timing <= LCDVT_VT_RESET;
      frame_control <= LCDVT_FC_RESET;
    end
    else if (i_bus.wr)
    begin
      if (reg_sel(i_bus.addr) == 2'b01)
        vertical_timing <= i_bus.wdata;
      if (reg_sel(i_bus.addr) == 2'b10)
        frame_control <= i_bus.wdata & LCDVT_FC_MASK;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_rdata <= 32'h00000000;
    else if (i_bus.rd)
    begin
      if (reg_sel(i_bus.addr) == 2'b01)
        o_rdata <= vertical_timing;
      else if (reg_sel(i_bus.addr) == 2'b10)
        o_rdata <= frame_control;
      else
        o_rdata <= 32'h00000000;
    end
    else
      o_rdata <= 32'h00000000;
  end

  // Terminal count of the present phase; fields are read live, so a
  // rewrite takes effect at the next phase boundary or compare
  always_comb
  begin
    case (state)
      LCDVT_SYNC: last = ({4'h0, count} ==
        {4'h0, 4'h0, vertical_timing[LCDVT_SW_POS +: 6]});
      LCDVT_BACK: last = (count == porch_end(vertical_timing[LCDVT_BP_POS +: 8]));
      LCDVT_DISP: last = (count == vertical_timing[LCDVT_LPS_POS +: 10]);
      LCDVT_FRONT: last = (count == {2'b00, vertical_timing[LCDVT_FP_POS +: 8]});
      default: last = 1'b1;
    endcase
  end

  // Phase order; a back porch of zero goes straight to display
  always_comb
  begin
    next_state = state;
    case (state)
      LCDVT_SYNC: next_state = (vertical_timing[LCDVT_BP_POS +: 8] == 8'h00) ?
        LCDVT_DISP : LCDVT_BACK;
      LCDVT_BACK: next_state = LCDVT_DISP;
      LCDVT_DISP: next_state = (vertical_timing[LCDVT_FP_POS +: 8] == 8'h00) ?
        LCDVT_SYNC : LCDVT_FRONT;
      LCDVT_FRONT: next_state = LCDVT_SYNC;
      default: next_state = LCDVT_SYNC;
    endcase
  end

  // Line counter advances on each line tick; state advances on the tick at the phase's last count
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state <= LCDVT_SYNC;
      count <= 10'h000;
    end
    else if (i_line_pulse)
    begin
      if (last)
      begin
        state <= next_state;
        count <= 10'h000;
      end
      else
        count <= count + 10'h001;
    end
  end

  // Registered outputs, one cycle behind the state
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_frame_sync <= 1'b0;
      o_display_line <= 1'b0;
      o_dummy_line <= 1'b0;
      o_line <= 10'h000;
    end
    else
    begin
      // Passive panels get dummy lines instead of a pulse
      o_frame_sync <= ((state == LCDVT_SYNC) && i_active) ^
        frame_control[LCDVT_INV_FRAME_POS];
      o_dummy_line <= (state == LCDVT_SYNC) && !i_active;
      o_display_line <= (state == LCDVT_DISP);
      o_line <= (state == LCDVT_DISP) ? count : 10'h000;
    end
  end

  // Phase lengths and order; the checks read the fields live, as the counter does
  AST_SYNC_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && i_line_pulse &&
     count < {4'h0, vertical_timing[LCDVT_SW_POS +: 6]}) |=> state == LCDVT_SYNC)
    else $error("Sync phase ended early");
  AST_SYNC_END: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && i_line_pulse &&
     count == {4'h0, vertical_timing[LCDVT_SW_POS +: 6]}) |=> state != LCDVT_SYNC)
    else $error("Sync phase overran");
  AST_BP_AFTER_SYNC: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_BACK && $changed(state)) |-> $past(state) == LCDVT_SYNC)
    else $error("Back porch not after sync");
  AST_BP_SKIP: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && i_line_pulse && vertical_timing[LCDVT_BP_POS +: 8] == 8'h00 &&
     count == {4'h0, vertical_timing[LCDVT_SW_POS +: 6]}) |=> state == LCDVT_DISP)
    else $error("Zero back porch not skipped");
  AST_BP_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_BACK && i_line_pulse &&
     count != porch_end(vertical_timing[LCDVT_BP_POS +: 8])) |=> state == LCDVT_BACK)
    else $error("Back porch length wrong");
  AST_BP_END: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_BACK && i_line_pulse &&
     count == porch_end(vertical_timing[LCDVT_BP_POS +: 8])) |=> state == LCDVT_DISP)
    else $error("Display did not follow back porch");
  AST_DISP_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_DISP && i_line_pulse && count ==
     vertical_timing[LCDVT_LPS_POS +: 10]) |=> state != LCDVT_DISP)
    else $error("Display lines wrong");
  AST_FP_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_FRONT && i_line_pulse &&
     count != {2'b00, vertical_timing[LCDVT_FP_POS +: 8]}) |=> state == LCDVT_FRONT)
    else $error("Front porch length wrong");
  AST_ORDER: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && $changed(state)) |->
    ($past(state) == LCDVT_FRONT || $past(state) == LCDVT_DISP))
    else $error("Frame order broken");

  // Output pins in the two panel modes
  AST_PASSIVE_NO_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !i_active |=> o_frame_sync == $past(frame_control[LCDVT_INV_FRAME_POS]))
    else $error("Passive mode produced sync pulse");
  AST_SYNC_PULSE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && i_active) |=>
    o_frame_sync != $past(frame_control[LCDVT_INV_FRAME_POS]))
    else $error("Active sync pulse missing");
  AST_DUMMY: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_SYNC && !i_active) |=> o_dummy_line)
    else $error("Dummy line missing");
  AST_NO_DUMMY_ACTIVE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_active |=> !o_dummy_line)
    else $error("Dummy line in active mode");
  AST_DISP_FLAG: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state == LCDVT_DISP) |=> o_display_line)
    else $error("Display line flag missing");
  AST_LINE_IDLE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !o_display_line |-> o_line == 10'h000)
    else $error("Line index outside display");

  // Register port; read data must be the register as it stood at the strobe
  AST_FC_READ: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_bus.rd && i_bus.addr == LCDVT_OFS_FRAME_CONTROL) |=>
    o_rdata == $past(frame_control))
    else $error("Frame control read wrong");
  AST_VT_READ: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_bus.rd && i_bus.addr == LCDVT_OFS_VERTICAL_TIMING) |=>
    o_rdata == $past(vertical_timing))
    else $error("Vertical timing read wrong");
  AST_RESERVED: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    frame_control[31:28] == 4'h0)
    else $error("Reserved bits set");

  COV_ACTIVE_SYNC: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    i_active && state == LCDVT_SYNC ##1 state == LCDVT_BACK);
  COV_PASSIVE_DUMMY: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    o_dummy_line ##1 !o_dummy_line);
  COV_ZERO_BP: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    state == LCDVT_SYNC ##1 state == LCDVT_DISP);
  COV_FRONT: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    state == LCDVT_FRONT ##1 state == LCDVT_SYNC);
  COV_PASSIVE_PORCH: cover property (@(posedge i_clock) disable iff (!i_rst_b)
    !i_active && state == LCDVT_SYNC ##1 state == LCDVT_BACK);
endmodule
`default_nettype wire

// [sim/lcdvt_panel.sv]
/*
  Panel model: makes line ticks and measures runs of sync, porch and
  display lines. Assumes sequencer outputs move one cycle after a tick.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdvt_panel
(
  input wire logic i_clock, // Controller clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_sync, // Sync or dummy line, polarity removed
  input wire logic i_disp, // Display line
  output logic o_tick, // Line clock tick, every fourth cycle
  output logic [10:0] o_sync_n, // Length of last sync run
  output logic [10:0] o_idle_n, // Length of last porch run
  output logic [10:0] o_disp_n, // Length of last display run
  output logic [7:0] o_frames // Display runs finished
);
  logic [1:0] div;
  logic [1:0] cls;
  logic [1:0] last;
  logic [10:0] run;
  assign o_tick = (div == 2'h3);
  assign cls = i_disp ? 2'h2 : (i_sync ? 2'h1 : 2'h0);
  // Sampled at ticks, while the outputs still show the line that ends
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      {div, last, run, o_sync_n, o_idle_n, o_disp_n, o_frames} <= '0;
    end
    else
    begin
      div <= div + 2'h1;
      if (o_tick && cls == last)
        run <= run + 11'h1;
      else if (o_tick)
      begin
        run <= 11'h1;
        last <= cls;
        if (last == 2'h0) o_idle_n <= run;
        if (last == 2'h1) o_sync_n <= run;
        if (last == 2'h2) o_disp_n <= run;
        if (last == 2'h2) o_frames <= o_frames + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/lcdvt_top_tb_top.sv]
/*
  Testbench: register access and frame sequence checks through the panel.
  Assumes the package offsets and a plain one-cycle register port.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdvt_top_tb_top;
  import lcdvt_pkg::*;
  logic i_clock = 0, i_rst_b = 0, i_active = 1, inv = 0;
  lcdvt_bus_t bus = '0;
  logic [31:0] o_rdata, rv;
  logic o_frame_sync, o_display_line, o_dummy_line, tick;
  logic [9:0] o_line, top;
  logic [10:0] sync_n, idle_n, disp_n;
  logic [7:0] frames, f0;
  logic [31:0] cfg [4] = '{32'h01000001, 32'hff0017ff, 32'h02000803, 32'h0003fc00};
  logic act [4] = '{1, 1, 0, 1}; // Passive case runs slaved, so it may keep a porch
  int failures = 0, cmp_count = 0, w;
  always #25 i_clock = ~i_clock;
  lcdvt_top lcdvt_top_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_bus(bus),
    .i_active(i_active), .i_line_pulse(tick), .o_rdata(o_rdata),
    .o_frame_sync(o_frame_sync), .o_display_line(o_display_line),
    .o_dummy_line(o_dummy_line), .o_line(o_line));
  // Polarity is taken off so the panel sees one sync level
  lcdvt_panel lcdvt_panel_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_sync((o_frame_sync ^ inv) | o_dummy_line), .i_disp(o_display_line),
    .o_tick(tick), .o_sync_n(sync_n), .o_idle_n(idle_n), .o_disp_n(disp_n),
    .o_frames(frames));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1;
    @(posedge i_clock);
    bus.wr <= 0;
  endtask
  task rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge i_clock);
    bus.addr <= a;
    bus.rd <= 1;
    @(posedge i_clock);
    bus.rd <= 0;
    #1 v = o_rdata;
  endtask
  task tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the longest frame sequence
  initial
  begin
    #3000000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1;
    wr(LCDVT_OFS_FRAME_CONTROL, 32'hffffffff);
    rd(LCDVT_OFS_FRAME_CONTROL, rv);
    chk("frame_control", rv, LCDVT_FC_MASK);
    rd(32'h80010030, rv);
    chk("unmapped", rv, 32'h00000000);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
    begin
      inv = (i == 1);
      @(posedge i_clock);
      i_active <= act[i];
      // A passive porch is only allowed with the slave bit set
      wr(LCDVT_OFS_FRAME_CONTROL, {16'h0, ~act[i], 3'h0, inv, 11'h0});
      wr(LCDVT_OFS_VERTICAL_TIMING, cfg[i]);
      rd(LCDVT_OFS_VERTICAL_TIMING, rv);
      chk("vertical_timing", rv, cfg[i]);
      f0 = frames;
      w = 0;
      top = 10'h000;
      // Sampled mid-cycle so registered outputs are settled
      while (frames != f0 + 8'h2 && w < 12000)
      begin
        @(negedge i_clock);
        w++;
        if (o_display_line)
          top = o_line;
      end
      chk("frames", {24'h0, frames - f0}, 32'h00000002);
      chk("last line", {22'h0, top}, {22'h0, cfg[i][9:0]});
      chk("sync lines", {21'h0, sync_n}, cfg[i][15:10] + 32'h1);
      chk("display lines", {21'h0, disp_n}, cfg[i][9:0] + 32'h1);
      if (cfg[i][31:24] != 8'h0)
        chk("porch lines", {21'h0, idle_n}, {24'h0, cfg[i][31:24]});
      else if (cfg[i][23:16] != 8'h0)
        chk("front lines", {21'h0, idle_n}, {24'h0, cfg[i][23:16]} + 32'h1);
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
